// ===== stm_regs.svh
`ifndef STM_REGS_SVH
`define STM_REGS_SVH

// Register indices on the byte-wide port
`define STM_ADDR_CTRL0      3'h0
`define STM_ADDR_CTRL1      3'h1
`define STM_ADDR_CNT_LO     3'h2
`define STM_ADDR_CNT_HI     3'h3
`define STM_ADDR_CMPA_LO    3'h4
`define STM_ADDR_CMPA_HI    3'h5
`define STM_ADDR_PERIOD     3'h6
`define STM_ADDR_FLAGS      3'h7

// Control 0 fields
`define STM_C0_PAUSE        7
`define STM_C0_ENABLE       3
// Control 1 fields
`define STM_C1_MODE_HI      7
`define STM_C1_MODE_LO      6
`define STM_C1_ACT_HI       5
`define STM_C1_ACT_LO       4
`define STM_C1_OUTCTL       3
`define STM_C1_POL          2
`define STM_C1_SWAP         1
`define STM_C1_CLRSEL       0
// Flag register fields
`define STM_FL_A            0
`define STM_FL_P            1

`define STM_RESET_BYTE      8'h00
`define STM_RESET_WORD      16'h0000
`define STM_CNT_MAX         16'hFFFF
`define STM_CNT_ONE         16'h0001
`define STM_LOW_BYTE        8'h00

`endif

// ===== stm_pkg.sv
package stm_pkg;
	typedef enum logic [1:0] {
		STM_MODE_CMP = 2'h0,
		STM_MODE_CAP = 2'h1,
		STM_MODE_PWM = 2'h2,
		STM_MODE_TMR = 2'h3
	} stm_mode_t;
	typedef enum logic [1:0] {
		STM_ACT_0 = 2'h0,
		STM_ACT_1 = 2'h1,
		STM_ACT_2 = 2'h2,
		STM_ACT_3 = 2'h3
	} stm_act_t;
endpackage

// ===== stm_timer.sv
// Behaviour
// - Clear-select zero: period match or overflow clears the counter.
// - Overflow at FFFF clears the counter in every mode, whatever the period register holds.
// - Clear-select ignored in PWM and capture modes.
// - Counter readable as two read-only bytes, zero after reset.
// - Compare A held in two read/write bytes, reset zero.
// - Period compares counter bits 15..8; zero means 65536 counter ticks.
// - Mode 00 is compare-match; clears by overflow, A or P match.
// - Compare-match, clear-select zero: both A and P flags set.
// - Clear-select one: A match clears, only A flag, never P.
// - Compare A zero: counter overflows at FFFF without A flag.
// - In compare-match mode, apart from enable rising, pin changes only on an A match that sets the A flag.
// - Pin action high, low, toggle or none on A match.
// - Enable rising edge returns pin to output-control level.
// - Mode 11 behaves like compare-match but drives no pin.
// - Swap bit chooses which register sets period and which duty.
// - In PWM, A flag on A match, P flag on period match.
// - Swap zero: period match clears counter; duty is compare A.
// - Duty at or above period gives a 100 percent output.
// - Swap one: period from compare A, duty from period register.
// - Polarity inverts pin; in PWM output-control picks active level.
// - PWM counting continues while pin is forced.
// - Compare-match action: 00 none, 01 low, 10 high, 11 toggle.
// - Enable rising clears counter; falling holds its value.
// - PWM action: 00 inactive, 01 active, 10 PWM, 11 holds the output-control level set on enable rising.
// - Output-control 0 active low, 1 active high in PWM.
`timescale 1ns/1ps
`default_nettype none
`include "stm_regs.svh"

module stm_timer #(
	parameter int CNT_DIV = 4
) (
	input  wire logic       SYS_CLK,
	input  wire logic       RESET_N,
	input  wire logic [2:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output var  logic [7:0] RDATA,
	output var  logic       TIMER_OUTPUT_PIN,
	output var  logic       PIN_DRIVE_EN_N,
	output var  logic       COMPARE_A_FLAG,
	output var  logic       PERIOD_MATCH_FLAG
);
	logic        rst_s1_reg;
	logic        rst_n;
	logic [7:0]  ctrl0_reg;
	logic [7:0]  ctrl1_reg;
	logic [15:0] cmpa_reg;
	logic [7:0]  period_reg;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [15:0] cnt_inc;
	logic        en_d_reg;
	logic        wave_reg;
	logic        fa_reg;
	logic        fp_reg;
	logic [7:0]  rdata_next;
	logic [$clog2(CNT_DIV+1)-1:0] div_reg;
	logic        tick;
	logic        enable;
	logic        en_rise;
	logic        match_a;
	logic        match_p;
	logic        overflow;
	logic        set_a;
	logic        set_p;
	logic        clear_cnt;
	logic        duty_hit;
	logic        wr_flags;
	logic        pin_next;
	stm_pkg::stm_mode_t mode;
	stm_pkg::stm_act_t  act;

	// Every flop leaves reset on the same edge; a raw release could split the state
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	assign mode    = stm_pkg::stm_mode_t'({ctrl1_reg[`STM_C1_MODE_HI], ctrl1_reg[`STM_C1_MODE_LO]});
	assign act     = stm_pkg::stm_act_t'({ctrl1_reg[`STM_C1_ACT_HI], ctrl1_reg[`STM_C1_ACT_LO]});
	assign enable  = ctrl0_reg[`STM_C0_ENABLE];
	assign en_rise = enable && !en_d_reg;
	assign wr_flags = WR && (ADDR == `STM_ADDR_FLAGS);

	// Count clock enable from a divider of the system clock
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= '0;
		end else if (div_reg == ($clog2(CNT_DIV+1))'(CNT_DIV - 1)) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end
	assign tick = (div_reg == ($clog2(CNT_DIV+1))'(CNT_DIV - 1));

	// Register writes
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl0_reg  <= `STM_RESET_BYTE;
			ctrl1_reg  <= `STM_RESET_BYTE;
			cmpa_reg   <= `STM_RESET_WORD;
			period_reg <= `STM_RESET_BYTE;
		end else if (WR) begin
			case (ADDR)
				`STM_ADDR_CTRL0: begin
					ctrl0_reg <= {WDATA[7:3], 3'h0};
				end
				`STM_ADDR_CTRL1: begin
					ctrl1_reg <= WDATA;
				end
				`STM_ADDR_CMPA_LO: begin
					cmpa_reg[7:0] <= WDATA;
				end
				`STM_ADDR_CMPA_HI: begin
					cmpa_reg[15:8] <= WDATA;
				end
				`STM_ADDR_PERIOD: begin
					period_reg <= WDATA;
				end
				default: begin
				end
			endcase
		end
	end

	// Comparators look at the next count, so a value of N gives exactly N ticks
	assign cnt_inc  = cnt_reg + `STM_CNT_ONE;
	assign match_a  = (cnt_inc == cmpa_reg) && (cmpa_reg != `STM_RESET_WORD);
	assign match_p  = (cnt_inc[15:8] == period_reg) && (cnt_inc[7:0] == `STM_LOW_BYTE)
		&& (period_reg != `STM_RESET_BYTE);
	assign overflow = (cnt_reg == `STM_CNT_MAX);

	always_comb begin
		set_a     = 1'b0;
		set_p     = 1'b0;
		clear_cnt = 1'b0;
		case (mode)
			stm_pkg::STM_MODE_CMP, stm_pkg::STM_MODE_TMR: begin
				set_a = match_a;
				if (ctrl1_reg[`STM_C1_CLRSEL]) begin
					clear_cnt = match_a || overflow;
				end else begin
					set_p     = match_p;
					clear_cnt = match_p || overflow;
				end
			end
			stm_pkg::STM_MODE_PWM: begin
				// Clear-select plays no part here
				// A wrap restarts the period too, so a zero value still gives 65536 ticks
				set_a = match_a;
				set_p = match_p;
				if (ctrl1_reg[`STM_C1_SWAP]) begin
					clear_cnt = match_a || overflow;
				end else begin
					clear_cnt = match_p || overflow;
				end
			end
			default: begin
				set_p     = match_p;
				clear_cnt = match_p || overflow;
			end
		endcase
	end

	// Overflow wraps to zero which covers the all-zero period case
	always_comb begin
		if (clear_cnt) begin
			cnt_next = `STM_RESET_WORD;
		end else begin
			cnt_next = cnt_inc;
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg  <= `STM_RESET_WORD;
			en_d_reg <= 1'b0;
		end else begin
			en_d_reg <= enable;
			if (en_rise) begin
				cnt_reg <= `STM_RESET_WORD;
			end else if (enable && tick && !ctrl0_reg[`STM_C0_PAUSE]) begin
				cnt_reg <= cnt_next;
			end
		end
	end

	wire step = enable && tick && !ctrl0_reg[`STM_C0_PAUSE] && !en_rise;

	// Flags: a hardware set beats a same-cycle software clear
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			fa_reg <= 1'b0;
			fp_reg <= 1'b0;
		end else begin
			fa_reg <= (step && set_a) || (fa_reg && !(wr_flags && WDATA[`STM_FL_A]));
			fp_reg <= (step && set_p) || (fp_reg && !(wr_flags && WDATA[`STM_FL_P]));
		end
	end

	// Duty reached when counter hits duty; zero duty in swap mode means 65536
	always_comb begin
		if (ctrl1_reg[`STM_C1_SWAP]) begin
			duty_hit = match_p;
		end else begin
			duty_hit = match_a;
		end
	end

	// Waveform level: 1 means active. Duty >= period never hits before clear.
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			wave_reg <= 1'b0;
		end else if (en_rise) begin
			wave_reg <= 1'b1;
		end else if (step) begin
			if (clear_cnt) begin
				wave_reg <= 1'b1;
			end else if (duty_hit) begin
				wave_reg <= 1'b0;
			end
		end
	end

	// Pin level before polarity
	logic pin_reg;
	always_comb begin
		pin_next = pin_reg;
		if (en_rise) begin
			pin_next = ctrl1_reg[`STM_C1_OUTCTL];
		end else if (mode == stm_pkg::STM_MODE_CMP && step && set_a) begin
			case (act)
				stm_pkg::STM_ACT_1: pin_next = 1'b0;
				stm_pkg::STM_ACT_2: pin_next = 1'b1;
				stm_pkg::STM_ACT_3: pin_next = !pin_reg;
				default:            pin_next = pin_reg;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_reg <= 1'b0;
		end else begin
			pin_reg <= pin_next;
		end
	end

	// Output stage; PWM levels use the active level from output control
	logic pin_level;
	always_comb begin
		case (mode)
			stm_pkg::STM_MODE_PWM: begin
				case (act)
					stm_pkg::STM_ACT_0: pin_level = !ctrl1_reg[`STM_C1_OUTCTL];
					stm_pkg::STM_ACT_1: pin_level = ctrl1_reg[`STM_C1_OUTCTL];
					stm_pkg::STM_ACT_2: pin_level = wave_reg ~^ ctrl1_reg[`STM_C1_OUTCTL] ? 1'b1 : 1'b0;
					default:            pin_level = pin_reg;
				endcase
			end
			default: pin_level = pin_reg;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			TIMER_OUTPUT_PIN <= 1'b0;
			PIN_DRIVE_EN_N   <= 1'b1;
		end else begin
			TIMER_OUTPUT_PIN <= pin_level ^ ctrl1_reg[`STM_C1_POL];
			// Timer mode releases the pin for other uses
			PIN_DRIVE_EN_N <= (mode == stm_pkg::STM_MODE_TMR)
				|| (mode == stm_pkg::STM_MODE_CAP);
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			COMPARE_A_FLAG    <= 1'b0;
			PERIOD_MATCH_FLAG <= 1'b0;
		end else begin
			COMPARE_A_FLAG    <= fa_reg;
			PERIOD_MATCH_FLAG <= fp_reg;
		end
	end

	// Read port
	always_comb begin
		case (ADDR)
			`STM_ADDR_CTRL0:   rdata_next = ctrl0_reg;
			`STM_ADDR_CTRL1:   rdata_next = ctrl1_reg;
			`STM_ADDR_CNT_LO:  rdata_next = cnt_reg[7:0];
			`STM_ADDR_CNT_HI:  rdata_next = cnt_reg[15:8];
			`STM_ADDR_CMPA_LO: rdata_next = cmpa_reg[7:0];
			`STM_ADDR_CMPA_HI: rdata_next = cmpa_reg[15:8];
			`STM_ADDR_PERIOD:  rdata_next = period_reg;
			default:           rdata_next = {6'h0, fp_reg, fa_reg};
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			RDATA <= `STM_RESET_BYTE;
		end else if (RD) begin
			RDATA <= rdata_next;
		end else begin
			RDATA <= `STM_RESET_BYTE;
		end
	end

	// Assertions
	cnt_clear_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		en_rise |=> cnt_reg == `STM_RESET_WORD)
		else $error("counter not cleared");

	hold_off_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!enable && !$rose(enable) |=> $stable(cnt_reg))
		else $error("counter moved while off");

	no_pflag_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		mode != stm_pkg::STM_MODE_PWM && mode != stm_pkg::STM_MODE_CAP
		&& ctrl1_reg[`STM_C1_CLRSEL] && !fp_reg |=> !fp_reg)
		else $error("P flag with clear-select one");

	zero_a_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		cmpa_reg == `STM_RESET_WORD && !fa_reg && !$past(wr_flags) |=> !fa_reg)
		else $error("A flag with zero compare");

	aflag_set_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		step && match_a && mode == stm_pkg::STM_MODE_CMP |=> fa_reg)
		else $error("A flag missed");

	pin_init_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		en_rise |=> pin_reg == $past(ctrl1_reg[`STM_C1_OUTCTL]))
		else $error("pin not reset");

	pclear_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		step && match_p && mode == stm_pkg::STM_MODE_CMP && !ctrl1_reg[`STM_C1_CLRSEL]
		|=> cnt_reg == `STM_RESET_WORD)
		else $error("period clear missed");

	pin_hold_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		mode == stm_pkg::STM_MODE_CMP && !en_rise && !(step && set_a) |=> $stable(pin_reg))
		else $error("pin changed without A match");

	pwm_pflag_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		step && match_p && mode == stm_pkg::STM_MODE_PWM |=> fp_reg)
		else $error("P flag missed in PWM");

	pin_release_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		mode == stm_pkg::STM_MODE_TMR |=> PIN_DRIVE_EN_N)
		else $error("pin driven in timer mode");

	wave_restart_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		step && clear_cnt && mode == stm_pkg::STM_MODE_PWM |=> wave_reg)
		else $error("waveform not active after clear");

	force_active_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		mode == stm_pkg::STM_MODE_PWM && act == stm_pkg::STM_ACT_1
		|=> TIMER_OUTPUT_PIN
			== ($past(ctrl1_reg[`STM_C1_OUTCTL]) ^ $past(ctrl1_reg[`STM_C1_POL])))
		else $error("forced active level wrong");

	count_step_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		step && !clear_cnt |=> cnt_reg == $past(cnt_reg) + `STM_CNT_ONE)
		else $error("counter did not advance");

	rdata_idle_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!RD |=> RDATA == `STM_RESET_BYTE)
		else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct {logic [2:0] a; logic [7:0] d; logic w; logic [7:0] e;} stm_row_t;
	logic       sys_clk    = 1'b0;
	logic       reset_n    = 1'b0;
	logic [2:0] addr       = 3'h0;
	logic [7:0] wdata      = 8'h00;
	logic       wr         = 1'b0;
	logic       rd         = 1'b0;
	logic [7:0] rdata;
	logic       pin;
	logic       pin_en_n;
	logic       fa;
	logic       fp;
	int         failures   = 0;
	int         n_compared = 0;
	logic [7:0] v;
	logic [7:0] w;
	logic [7:0] c1;
	logic [3:0] ex         = 4'b0100;
	int         hi;
	stm_row_t   rows [10]  = '{'{3'h2, 8'h00, 1'b0, 8'h00}, '{3'h3, 8'h00, 1'b0, 8'h00},
		'{3'h4, 8'h00, 1'b0, 8'h00}, '{3'h5, 8'h00, 1'b0, 8'h00}, '{3'h6, 8'h00, 1'b0, 8'h00},
		'{3'h4, 8'hA5, 1'b1, 8'hA5}, '{3'h5, 8'h3C, 1'b1, 8'h3C}, '{3'h6, 8'h7E, 1'b1, 8'h7E},
		'{3'h2, 8'hFF, 1'b1, 8'h00}, '{3'h3, 8'hFF, 1'b1, 8'h00}};

	always #2 sys_clk = ~sys_clk;

	stm_timer #(.CNT_DIV(1)) stm_timer_i (
		.SYS_CLK          (sys_clk),
		.RESET_N          (reset_n),
		.ADDR             (addr),
		.WDATA            (wdata),
		.WR               (wr),
		.RD               (rd),
		.RDATA            (rdata),
		.TIMER_OUTPUT_PIN (pin),
		.PIN_DRIVE_EN_N   (pin_en_n),
		.COMPARE_A_FLAG   (fa),
		.PERIOD_MATCH_FLAG(fp)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		d = rdata;
	endtask

	// Stop first: mode and pin action must not change while counting
	task automatic setup(input logic [7:0] c, input logic [15:0] ca, input logic [7:0] per);
		wreg(3'h0, 8'h00);
		wreg(3'h1, c);
		wreg(3'h4, ca[7:0]);
		wreg(3'h5, ca[15:8]);
		wreg(3'h6, per);
		wreg(3'h7, 8'h03);
		wreg(3'h0, 8'h08);
	endtask

	task automatic wait_hi(input int sel);
		int k;
		k = 0;
		while (((sel == 0) ? fa : fp) !== 1'b1 && k < 2000) begin
			@(negedge sys_clk);
			k++;
		end
		chk(16'(k < 2000), 16'h0001);
	endtask

	// Counting high cycles over a whole period is independent of phase
	task automatic pwm(input logic [7:0] c, input logic [15:0] ca, input logic [7:0] per,
		input int win, input int exp);
		setup(c, ca, per);
		repeat (win) @(posedge sys_clk);
		hi = 0;
		repeat (win) begin
			@(negedge sys_clk);
			hi += int'(pin === 1'b1);
		end
		chk(16'(hi), 16'(exp));
	endtask

	task automatic summarize;
		$display("compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge sys_clk);
		failures++;
		summarize();
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 10; i++) begin
			if (rows[i].w) begin
				wreg(rows[i].a, rows[i].d);
			end
			rreg(rows[i].a, v);
			chk(16'(v), 16'(rows[i].e));
		end
		for (int act = 0; act < 4; act++) begin
			c1 = {2'b00, 2'(act), 1'(act), 3'b000};
			setup(c1, 16'h0010, 8'h01);
			repeat (4) @(negedge sys_clk);
			chk(16'(pin), 16'(c1[3]));
			chk(16'(pin_en_n), 16'h0000);
			wait_hi(0);
			repeat (3) @(negedge sys_clk);
			chk(16'(pin), 16'(ex[act]));
			wait_hi(1);
			rreg(3'h3, v);
			chk(16'(v), 16'h0000);
			chk(16'(pin), 16'(ex[act]));
		end
		setup(8'hC0, 16'h0010, 8'h01);
		wait_hi(0);
		chk(16'(pin_en_n), 16'h0001);
		setup(8'h01, 16'h0200, 8'h01);
		repeat (1200) @(negedge sys_clk);
		chk(16'(fa), 16'h0001);
		chk(16'(fp), 16'h0000);
		rreg(3'h3, v);
		chk(16'(v[7:1]), 16'h0000);
		wreg(3'h0, 8'h00);
		rreg(3'h2, v);
		rreg(3'h2, w);
		chk(16'(w), 16'(v));
		setup(8'h00, 16'h0000, 8'h01);
		repeat (300) @(negedge sys_clk);
		chk(16'({fa, fp}), 16'h0001);
		wreg(3'h0, 8'h88);
		rreg(3'h2, v);
		rreg(3'h2, w);
		chk(16'(w), 16'(v));
		wreg(3'h0, 8'h08);
		rreg(3'h2, w);
		chk(16'(w != v), 16'h0001);
		pwm(8'hA9, 16'h0040, 8'h01, 256, 64);
		chk(16'({fa, fp, pin_en_n}), 16'h0006);
		pwm(8'hA0, 16'h0040, 8'h01, 256, 192);
		pwm(8'hAC, 16'h0040, 8'h01, 256, 192);
		pwm(8'hA8, 16'h0100, 8'h01, 256, 256);
		pwm(8'h88, 16'h0040, 8'h01, 256, 0);
		chk(16'(fp), 16'h0001);
		pwm(8'h98, 16'h0040, 8'h01, 256, 256);
		pwm(8'hAA, 16'h0200, 8'h01, 512, 256);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk(16'({rdata, pin, pin_en_n, fa, fp}), 16'h0004);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rreg(3'h2, v);
		chk(16'(v), 16'h0000);
		rreg(3'h4, v);
		chk(16'(v), 16'h0000);
		summarize();
	end
endmodule
`default_nettype wire
